//--- core/zav_pkg.sv
// shared constants, types and variant decoding for the zone alarm decision block
package zav_pkg;
    localparam int NZ = 4;
    localparam int ND = 8;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int TW = 16;

    // register byte addresses; zone config and status step by one word per zone
    localparam logic [AW-1:0] ADDR_ZCFG0 = 8'h00;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h10;
    localparam logic [AW-1:0] ADDR_CMD = 8'h14;
    localparam logic [AW-1:0] ADDR_ACK_TIME = 8'h18;
    localparam logic [AW-1:0] ADDR_INV_TIME = 8'h1c;
    localparam logic [AW-1:0] ADDR_ZSTAT0 = 8'h20;
    localparam logic [AW-1:0] ADDR_STEP = 8'h04;

    localparam int CFG_VAR_LSB = 0;
    localparam int CFG_GA_LSB = 8;
    localparam int CFG_GB_LSB = 16;
    localparam int CTRL_UNATT_BIT = 0;
    localparam int CMD_ACK_LSB = 0;
    localparam int CMD_CLR_LSB = 4;
    localparam int STAT_PRE_BIT = 4;

    localparam logic [TW-1:0] ACK_TIME_RST = 16'h001e;
    localparam logic [TW-1:0] INV_TIME_RST = 16'h00b4;
    localparam logic [3:0] VAR_RST = 4'h1;

    // window lengths in seconds; the coincidence window is set in minutes
    localparam int WAIT_S = 40;
    localparam int REARM_S = 60;
    localparam int COINC_MIN = 8;
    localparam int SEC_PER_MIN = 60;
    localparam logic [TW-1:0] WAIT_TM = TW'(WAIT_S);
    localparam logic [TW-1:0] REARM_TM = TW'(REARM_S);
    localparam logic [TW-1:0] COINC_TM = TW'(COINC_MIN * SEC_PER_MIN);

    localparam int CLK_PERIOD_NS = 40;
    localparam int SEC_NS = 1000000000;
    localparam int TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;

    localparam logic [3:0] VAR_TWO = 4'h2;
    localparam logic [3:0] VAR_CLR1 = 4'h3;
    localparam logic [3:0] VAR_CLR2 = 4'h4;
    localparam logic [3:0] VAR_DET1 = 4'h5;
    localparam logic [3:0] VAR_DET2 = 4'h6;
    localparam logic [3:0] VAR_GRP1 = 4'h7;
    localparam logic [3:0] VAR_GRP2 = 4'h8;
    localparam logic [3:0] VAR_INT1 = 4'h9;
    localparam logic [3:0] VAR_INT2 = 4'ha;
    localparam logic [3:0] VAR_ZDET = 4'hb;
    localparam logic [3:0] VAR_ZGRP = 4'hc;
    localparam logic [3:0] VAR_SMCP = 4'hd;
    localparam logic [3:0] VAR_SDET = 4'he;
    localparam logic [3:0] VAR_ZESC = 4'hf;

    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT, ST_REARM, ST_COINC, ST_INTER, ST_STAGE1, ST_INVEST, ST_STAGE2
    } zav_state_t;

    typedef struct packed {
        logic prealarm;
        logic stage1;
        logic stage2;
        logic zone_alarm;
    } zav_zone_out_t;

    typedef struct packed {
        logic two_stage;
        logic clear40;
        logic coinc_det;
        logic coinc_grp;
        logic interact;
        logic accel;
        logic sys_mcp;
        logic sys_det;
        logic zone_esc;
        logic mcp_two;
    } zav_attr_t;

    // variant 1 and any unused code fall back to plain single stage
    function automatic zav_attr_t zav_decode(input logic [3:0] v);
        zav_attr_t a;
        a = '0;
        a.two_stage = 1'b1;
        case (v)
            VAR_TWO: a.two_stage = 1'b1;
            VAR_CLR1: {a.two_stage, a.clear40} = 2'h1;
            VAR_CLR2: a.clear40 = 1'b1;
            VAR_DET1: {a.two_stage, a.coinc_det} = 2'h1;
            VAR_DET2: a.coinc_det = 1'b1;
            VAR_GRP1: {a.two_stage, a.coinc_grp} = 2'h1;
            VAR_GRP2: a.coinc_grp = 1'b1;
            VAR_INT1: {a.two_stage, a.interact} = 2'h1;
            VAR_INT2: a.interact = 1'b1;
            VAR_ZDET: {a.clear40, a.coinc_det, a.accel} = 3'h7;
            VAR_ZGRP: {a.clear40, a.coinc_grp, a.accel} = 3'h7;
            VAR_SMCP: {a.accel, a.sys_mcp, a.mcp_two} = 3'h7;
            VAR_SDET: {a.accel, a.sys_det, a.mcp_two} = 3'h7;
            VAR_ZESC: {a.accel, a.zone_esc} = 2'h3;
            default: a.two_stage = 1'b0;
        endcase
        return a;
    endfunction
endpackage

//--- core/zav_tick.sv
// one-second tick generator shared by all zone timers
`timescale 1ns/1ps
module zav_tick #(
    parameter int CYCLES = zav_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    import zav_pkg::*;
    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    logic [31:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (cnt_ff >= LAST)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule

//--- core/zav_zone_fsm.sv
// per-zone alarm variant decision logic with register port
// What this block does
// - one-time clearing: second detector within 40 s raises the alarm
// - else clear detector, open 60 s window; trigger raises alarm, else false
// - two-stage clearing variant uses same windows, then acknowledge sequence
// - 2-detector coincidence: first trigger resets detector, asserts pre-alarm
// - cleared detector re-triggering within 8 minutes raises the alarm
// - 8 minute expiry drops pre-alarm and returns zone to supervision
// - two-stage 2-detector coincidence continues into acknowledge sequence
// - group trigger resets all detectors of that group, asserts pre-alarm
// - group A and group B triggers after the pre-alarm, within 8 minutes, raise the alarm
// - two-stage group coincidence continues into acknowledge sequence
// - interactive: pre-alarm arms zone; other detector confirming raises alarm
// - interactive: full alarm from one detector also raises alarm
// - two-stage interactive continues into acknowledge sequence
// - variants 11, 12: 40 s zone clearing, 8 min coincidence, acceleration
// - variants 13, 14: stage 1 escalates on any other call point or detector
// - variant 15: second zone detector during stage 1 escalates at once
// - stage 1 waits ack time, then investigate time, else stage 2
// - unattended mode makes two-stage variants raise stage 2 immediately
// - acceleration: two or more active zone detectors raise stage 2
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module zav_zone_fsm #(
    parameter int TICK_CYCLES = zav_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [zav_pkg::NZ*zav_pkg::ND-1:0] det_alarm_pin,
    input wire logic [zav_pkg::NZ*zav_pkg::ND-1:0] det_pre_pin,
    input wire logic [zav_pkg::NZ-1:0] manual_call_point_pin,
    input wire logic [zav_pkg::AW-1:0] addr,
    input wire logic [zav_pkg::DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [zav_pkg::DW-1:0] rdata,
    output zav_pkg::zav_zone_out_t [zav_pkg::NZ-1:0] zone_out,
    output logic [zav_pkg::NZ*zav_pkg::ND-1:0] det_reset
);
    import zav_pkg::*;
    localparam int NDET = NZ * ND;
    localparam int NIN = 2 * NDET + NZ;

    logic tick;
    zav_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // pin sampling: a change is taken once stages two and three agree
    logic [NIN-1:0] s1_ff, s2_ff, s3_ff, stable_ff, prev_ff;
    logic [NIN-1:0] agree;
    assign agree = ~(s2_ff ^ s3_ff);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_ff <= '0;
            prev_ff <= '0;
        end
        else
        begin
            s1_ff <= {manual_call_point_pin, det_pre_pin, det_alarm_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stable_ff <= (s3_ff & agree) | (stable_ff & ~agree);
            prev_ff <= stable_ff;
        end
    end

    logic [NIN-1:0] rise_all;
    logic [NDET-1:0] det_lvl_all, det_rise_all, pre_lvl_all, pre_rise_all;
    logic [NZ-1:0] mcp_rise_all;
    assign rise_all = stable_ff & ~prev_ff;
    assign det_lvl_all = stable_ff[NDET-1:0];
    assign det_rise_all = rise_all[NDET-1:0];
    assign pre_lvl_all = stable_ff[2*NDET-1:NDET];
    assign pre_rise_all = rise_all[2*NDET-1:NDET];
    assign mcp_rise_all = rise_all[NIN-1:2*NDET];

    // register file
    logic [23:0] cfg_ff [NZ];
    logic unattended_mode_ff;
    logic [TW-1:0] ack_wait_time_ff, investigate_time_ff;
    logic [NZ-1:0] ack_ff, clr_ff;
    logic [DW-1:0] rdata_ff;
    logic [7:0] zstat [NZ];

    function automatic logic [AW-1:0] zone_addr(input logic [AW-1:0] base, input int z);
        return base + AW'(z * 4);
    endfunction

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int z = 0; z < NZ; z++)
            begin
                cfg_ff[z] <= {16'h0000, 4'h0, VAR_RST};
            end
            unattended_mode_ff <= 1'b0;
            ack_wait_time_ff <= ACK_TIME_RST;
            investigate_time_ff <= INV_TIME_RST;
        end
        else if (wr)
        begin
            for (int z = 0; z < NZ; z++)
            begin
                if (addr == zone_addr(ADDR_ZCFG0, z))
                begin
                    cfg_ff[z] <= wdata[23:0];
                end
            end
            if (addr == ADDR_CTRL)
            begin
                unattended_mode_ff <= wdata[CTRL_UNATT_BIT];
            end
            if (addr == ADDR_ACK_TIME)
            begin
                ack_wait_time_ff <= wdata[TW-1:0];
            end
            if (addr == ADDR_INV_TIME)
            begin
                investigate_time_ff <= wdata[TW-1:0];
            end
        end
    end

    // operator commands are one-cycle pulses from a write to the command word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff <= '0;
            clr_ff <= '0;
        end
        else
        begin
            ack_ff <= (wr && addr == ADDR_CMD) ? wdata[CMD_ACK_LSB +: NZ] : '0;
            clr_ff <= (wr && addr == ADDR_CMD) ? wdata[CMD_CLR_LSB +: NZ] : '0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= '0;
            if (rd)
            begin
                for (int z = 0; z < NZ; z++)
                begin
                    if (addr == zone_addr(ADDR_ZCFG0, z))
                    begin
                        rdata_ff <= {8'h00, cfg_ff[z]};
                    end
                    if (addr == zone_addr(ADDR_ZSTAT0, z))
                    begin
                        rdata_ff <= {24'h000000, zstat[z]};
                    end
                end
                if (addr == ADDR_CTRL)
                begin
                    rdata_ff <= {31'h0000_0000, unattended_mode_ff};
                end
                if (addr == ADDR_ACK_TIME)
                begin
                    rdata_ff <= {16'h0000, ack_wait_time_ff};
                end
                if (addr == ADDR_INV_TIME)
                begin
                    rdata_ff <= {16'h0000, investigate_time_ff};
                end
            end
        end
    end
    assign rdata = rdata_ff;

    // one independent decision engine per zone
    for (genvar z = 0; z < NZ; z++)
    begin : g_zone
        zav_state_t st_ff;
        logic [TW-1:0] tm_ff;
        logic [ND-1:0] mask_ff, rst_ff;
        logic seen_a_ff, seen_b_ff;
        zav_zone_out_t out_ff;
        zav_attr_t a;
        logic [ND-1:0] lvl, rise, pre_lvl, pre_rise, ga, gb, grp_rst;
        logic [NDET-1:0] excl;
        logic exp, acc2, hit_a, hit_b, esc;
        zav_state_t raise_st;
        logic [TW-1:0] raise_tm, mcp_tm;
        zav_state_t mcp_st;

        assign a = zav_decode(cfg_ff[z][CFG_VAR_LSB +: 4]);
        assign ga = cfg_ff[z][CFG_GA_LSB +: ND];
        assign gb = cfg_ff[z][CFG_GB_LSB +: ND];
        assign lvl = det_lvl_all[z*ND +: ND];
        assign rise = det_rise_all[z*ND +: ND];
        assign pre_lvl = pre_lvl_all[z*ND +: ND];
        assign pre_rise = pre_rise_all[z*ND +: ND];
        assign exp = tick && (tm_ff <= 16'h0001);
        assign acc2 = a.accel && ((lvl & (lvl - 8'h01)) != '0);
        assign hit_a = |(rise & ga);
        assign hit_b = |(rise & gb);
        assign grp_rst = ({ND{hit_a}} & ga) | ({ND{hit_b}} & gb);

        // two-stage variants enter stage 1 unless the panel is unattended
        assign raise_st = (a.two_stage && !unattended_mode_ff) ? ST_STAGE1 : ST_STAGE2;
        assign raise_tm = ack_wait_time_ff;
        assign mcp_st = (a.mcp_two && !unattended_mode_ff) ? ST_STAGE1 : ST_STAGE2;
        assign mcp_tm = ack_wait_time_ff;

        always_comb
        begin
            excl = det_rise_all;
            excl[z*ND +: ND] = rise & ~mask_ff;
        end
        assign esc = acc2 || unattended_mode_ff
            || (a.zone_esc && |(rise & ~mask_ff))
            || (a.sys_det && |excl) || (a.sys_mcp && |mcp_rise_all);

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                st_ff <= ST_IDLE;
                tm_ff <= '0;
                mask_ff <= '0;
                rst_ff <= '0;
                seen_a_ff <= 1'b0;
                seen_b_ff <= 1'b0;
            end
            else
            begin
                rst_ff <= '0;
                if (tick && tm_ff != '0)
                begin
                    tm_ff <= tm_ff - 16'h0001;
                end
                case (st_ff)
                    ST_IDLE:
                    begin
                        if (mcp_rise_all[z])
                        begin
                            st_ff <= mcp_st;
                            tm_ff <= mcp_tm;
                        end
                        else if (|rise)
                        begin
                            mask_ff <= rise;
                            if (acc2)
                            begin
                                st_ff <= ST_STAGE2;
                            end
                            else if (a.clear40)
                            begin
                                st_ff <= ST_WAIT;
                                tm_ff <= WAIT_TM;
                            end
                            else if (a.coinc_det)
                            begin
                                rst_ff <= rise;
                                st_ff <= ST_COINC;
                                tm_ff <= COINC_TM;
                            end
                            else if (a.coinc_grp)
                            begin
                                if (hit_a || hit_b)
                                begin
                                    rst_ff <= grp_rst;
                                    seen_a_ff <= 1'b0;
                                    seen_b_ff <= 1'b0;
                                    st_ff <= ST_COINC;
                                    tm_ff <= COINC_TM;
                                end
                            end
                            else
                            begin
                                st_ff <= raise_st;
                                tm_ff <= raise_tm;
                            end
                        end
                        else if (a.interact && |pre_rise)
                        begin
                            mask_ff <= pre_rise;
                            st_ff <= ST_INTER;
                        end
                    end
                    ST_WAIT:
                    begin
                        if (acc2)
                        begin
                            st_ff <= ST_STAGE2;
                        end
                        else if (!a.coinc_det && !a.coinc_grp && |(rise & ~mask_ff))
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (exp && (a.coinc_det || a.coinc_grp))
                        begin
                            rst_ff <= '1;
                            seen_a_ff <= 1'b0;
                            seen_b_ff <= 1'b0;
                            st_ff <= ST_COINC;
                            tm_ff <= COINC_TM;
                        end
                        else if (exp)
                        begin
                            rst_ff <= mask_ff;
                            st_ff <= ST_REARM;
                            tm_ff <= REARM_TM;
                        end
                    end
                    ST_REARM:
                    begin
                        if (|rise)
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (exp)
                        begin
                            st_ff <= ST_IDLE;
                        end
                    end
                    ST_COINC:
                    begin
                        seen_a_ff <= seen_a_ff | hit_a;
                        seen_b_ff <= seen_b_ff | hit_b;
                        if (acc2)
                        begin
                            st_ff <= ST_STAGE2;
                        end
                        else if (a.coinc_det && !a.clear40 && |(rise & mask_ff))
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (a.coinc_det && a.clear40 && |(rise & ~mask_ff))
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (a.coinc_grp && (seen_a_ff || hit_a) && (seen_b_ff || hit_b))
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (exp)
                        begin
                            st_ff <= ST_IDLE;
                        end
                    end
                    ST_INTER:
                    begin
                        if (|rise || |(pre_rise & ~mask_ff))
                        begin
                            st_ff <= raise_st;
                            tm_ff <= raise_tm;
                        end
                        else if (pre_lvl == '0)
                        begin
                            st_ff <= ST_IDLE;
                        end
                    end
                    ST_STAGE1:
                    begin
                        if (esc || exp)
                        begin
                            st_ff <= ST_STAGE2;
                        end
                        else if (ack_ff[z])
                        begin
                            st_ff <= ST_INVEST;
                            tm_ff <= investigate_time_ff;
                        end
                    end
                    ST_INVEST:
                    begin
                        if (clr_ff[z])
                        begin
                            st_ff <= ST_IDLE;
                        end
                        else if (esc || exp)
                        begin
                            st_ff <= ST_STAGE2;
                        end
                    end
                    ST_STAGE2:
                    begin
                        if (clr_ff[z])
                        begin
                            st_ff <= ST_IDLE;
                        end
                    end
                    default: st_ff <= ST_IDLE;
                endcase
            end
        end

        // outputs follow the state one clock later so every port is a flop
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                out_ff <= '0;
            end
            else
            begin
                out_ff.prealarm <= (st_ff == ST_COINC);
                out_ff.stage1 <= (st_ff == ST_STAGE1) || (st_ff == ST_INVEST);
                out_ff.stage2 <= (st_ff == ST_STAGE2);
                out_ff.zone_alarm <= (st_ff == ST_STAGE1) || (st_ff == ST_INVEST)
                    || (st_ff == ST_STAGE2);
            end
        end

        assign zone_out[z] = out_ff;
        assign det_reset[z*ND +: ND] = rst_ff;
        assign zstat[z] = {out_ff.zone_alarm, out_ff.stage2, out_ff.stage1,
            out_ff.prealarm, 4'(st_ff)};
    end
endmodule

//--- tb/zav_zone_fsm_asserts.sv
// port checker for the zone alarm decision block
`timescale 1ns/1ps
module zav_zone_fsm_asserts import zav_pkg::*; #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NZ*ND-1:0] det_alarm_pin,
    input wire logic [NZ*ND-1:0] det_pre_pin,
    input wire logic [NZ-1:0] manual_call_point_pin,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DW-1:0] rdata,
    input wire zav_zone_out_t [NZ-1:0] zone_out,
    input wire logic [NZ*ND-1:0] det_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    zav_zone_out_t z0;
    logic clr0;
    logic clr_z0;
    assign z0 = zone_out[0];
    // any clearing pulse on a zone 0 head
    assign clr_z0 = |det_reset[ND-1:0];
    // a clear reaches the outputs within three edges of its write
    assign clr0 = wr && addr == ADDR_CMD && wdata[CMD_CLR_LSB];
    alarm_or_a: assert property (z0.zone_alarm == (z0.stage1 | z0.stage2))
        else $error("zone alarm bad");
    stage_excl_a: assert property (!(z0.stage1 && z0.stage2))
        else $error("both stages");
    pre_excl_a: assert property (z0.prealarm |-> !z0.zone_alarm)
        else $error("pre-alarm in alarm");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
        else $error("stray read data");
    cmd_read_a: assert property (rd && addr == ADDR_CMD |=> rdata == '0)
        else $error("command reads nonzero");
    reset_pulse_a: assert property (|det_reset |=> (det_reset & $past(det_reset)) == '0)
        else $error("long detector reset");
    pre_clear_a: assert property ($rose(z0.prealarm) |-> $past(clr_z0))
        else $error("pre-alarm without clearing");
    stage2_hold_a: assert property ($fell(z0.stage2) |->
        $past(clr0) || $past(clr0, 2) || $past(clr0, 3)) else $error("stage 2 lost");
    stage1_exit_a: assert property ($fell(z0.stage1) |->
        z0.stage2 || $past(clr0) || $past(clr0, 2) || $past(clr0, 3)) else $error("stage 1 lost");
    cover property ($rose(z0.stage2));
    cover property ($rose(z0.stage1));
    cover property ($rose(z0.prealarm));
endmodule
bind zav_zone_fsm zav_zone_fsm_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk, .rst,
    .det_alarm_pin, .det_pre_pin, .manual_call_point_pin, .addr, .wdata, .wr, .rd, .rdata,
    .zone_out, .det_reset);

//--- tb/zav_det_model.sv
// detector heads of all zones: alarm while fire is present, quiet after a panel reset
`timescale 1ns/1ps
module zav_det_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] fire,
    input wire logic [31:0] det_reset,
    output logic [31:0] det_alarm_pin
);
    logic [31:0] clr_ff;
    logic [31:0] alarm_ff;
    assign det_alarm_pin = alarm_ff;
    // a reset head stays quiet until its fire goes away, so a re-trigger needs a new fire
    always_ff @(posedge clk or posedge rst)
        if (rst)
            {clr_ff, alarm_ff} <= '0;
        else
        begin
            clr_ff <= (clr_ff | det_reset) & fire;
            alarm_ff <= fire & ~(clr_ff | det_reset);
        end
endmodule

//--- tb/zav_zone_fsm_tb.sv
// self-checking bench for the zone alarm decision block
`timescale 1ns/1ps
module zav_zone_fsm_tb;
    import zav_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0, rdata;
    logic [31:0] fire = '0, pre = '0, dal, drs;
    logic [3:0] mcp = '0;
    int error_cnt = 0, comparisons = 0;
    initial forever #20 clk = ~clk;
    zav_zone_fsm #(.TICK_CYCLES(10)) i_dut (.clk, .rst, .det_alarm_pin(dal), .det_pre_pin(pre),
        .manual_call_point_pin(mcp), .addr, .wdata, .wr, .rd, .rdata, .zone_out(), .det_reset(drs));
    zav_det_model i_det (.clk, .rst, .fire, .det_reset(drs), .det_alarm_pin(dal));
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        comparisons++;
        if (rdata !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t addr %h got %h exp %h", $time, a, rdata, e);
        end
    endtask
    // v: zone config first if nonzero; k: 0 fire, 1 pre-alarm, 2 command, 4 call point
    task automatic act(input int v, k, b, s, z, input logic [7:0] e);
        if (v != 0)
            wreg(ADDR_ZCFG0 + AW'(z * 4), DW'(v));
        @(posedge clk);
        if (k == 0)
            fire[b] <= 1'b0;
        if (k == 1)
            pre[b] <= ~pre[b];
        if (k == 4)
            mcp[b] <= ~mcp[b];
        if (k == 2)
            wreg(ADDR_CMD, DW'(b));
        // the gap outlasts the input filter so a lit head is seen to fire anew
        repeat (6) @(posedge clk);
        if (k == 0)
            fire[b] <= 1'b1;
        repeat (s * 10) @(posedge clk);
        rreg(ADDR_ZSTAT0 + AW'(z * 4), DW'(e));
        if (e[6])
        begin
            wreg(ADDR_CMD, 32'hf0);
            {fire, pre, mcp} <= '0;
        end
        $display("step done, %0d checks", comparisons);
    endtask
    task automatic give_verdict();
        $display("%0d checks, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(ADDR_ZCFG0, 32'h1);
        rreg(ADDR_ACK_TIME, 32'h1e);
        rreg(ADDR_INV_TIME, 32'hb4);
        rreg(ADDR_CMD, 32'h0);
        rreg(8'hfc, 32'h0);
        wreg(ADDR_ACK_TIME, 32'h8);
        wreg(ADDR_INV_TIME, 32'h5);
        act(3,0,0,1,0,8'h01);
        act(0,0,1,1,0,8'hc7);
        act(0,0,0,45,0,8'h02);
        act(0,0,0,1,0,8'hc7);
        act(0,0,0,105,0,8'h00);
        act(4,0,0,45,0,8'h02);
        act(0,0,2,1,0,8'ha5);
        act(0,2,1,1,0,8'ha6);
        act(0,9,0,6,0,8'hc7);
        act(5,0,0,1,0,8'h13);
        act(0,0,0,1,0,8'hc7);
        act(0,0,0,470,0,8'h13);
        act(0,9,0,15,0,8'h00);
        act(6,0,0,1,0,8'h13);
        act(0,0,0,1,0,8'ha5);
        act(0,9,0,9,0,8'hc7);
        act(32'h000c0307,0,0,1,0,8'h13);
        act(0,0,1,1,0,8'h13);
        act(0,0,2,1,0,8'hc7);
        act(9,1,0,1,0,8'h04);
        act(0,1,1,1,0,8'hc7);
        act(0,0,3,1,0,8'hc7);
        act(10,0,3,1,0,8'ha5);
        act(0,9,0,9,0,8'hc7);
        act(11,0,0,1,0,8'h01);
        act(0,0,1,1,0,8'hc7);
        act(0,0,0,45,0,8'h13);
        act(0,0,1,1,0,8'ha5);
        act(0,9,0,9,0,8'hc7);
        act(32'h000c0308,0,0,1,0,8'h13);
        act(0,0,1,1,0,8'h13);
        act(0,0,2,1,0,8'ha5);
        act(0,9,0,9,0,8'hc7);
        wreg(ADDR_CTRL, 32'h1);
        act(2,0,0,1,0,8'hc7);
        wreg(ADDR_CTRL, 32'h0);
        act(15,0,0,1,0,8'ha5);
        act(0,0,1,1,0,8'hc7);
        act(13,0,8,1,1,8'ha5);
        act(0,9,0,0,0,8'h00);
        act(0,4,0,1,1,8'hc7);
        give_verdict();
    end
endmodule
